// ---- twbc_pkg.sv ----
// Constants and types shared by the two-wire bus control block.
// Assumes an 8-bit special-function register bus and a free-running link clock.
package twbc_pkg;

	// Register address, reset value and field positions
	localparam logic [7:0] TWBC_CTRL_ADDR  = 8'hc0;
	localparam logic [7:0] TWBC_CTRL_RESET = 8'h00;
	localparam int         TWBC_MASTER_BIT = 7;
	localparam int         TWBC_TX_BIT     = 6;
	localparam int         TWBC_BEGIN_BIT  = 5;
	localparam int         TWBC_HALT_BIT   = 4;
	localparam int         TWBC_ACKRQ_BIT  = 3;
	localparam int         TWBC_ARB_BIT    = 2;
	localparam int         TWBC_ACK_BIT    = 1;
	localparam int         TWBC_SI_BIT     = 0;

	// Link timing: condition hold time, rounded up to link clock cycles
	localparam int         TWBC_LINK_NS    = 48;
	localparam int         TWBC_HOLD_NS    = 600;
	localparam logic [4:0] TWBC_HOLD_CYC   =
		5'((TWBC_HOLD_NS + TWBC_LINK_NS - 1) / TWBC_LINK_NS);

	// Event toggles from the link domain to the register domain
	localparam int TWBC_EV_START   = 0;
	localparam int TWBC_EV_STOP    = 1;
	localparam int TWBC_EV_ACKSLOT = 2;
	localparam int TWBC_EV_ACKVAL  = 3;
	localparam int TWBC_EV_STARTED = 4;
	localparam int TWBC_EV_ARB     = 5;
	localparam int TWBC_EV_W       = 6;

	// Control levels from the register domain to the link domain
	localparam int TWBC_CT_STA    = 0;
	localparam int TWBC_CT_STO    = 1;
	localparam int TWBC_CT_ACK    = 2;
	localparam int TWBC_CT_REL    = 3;
	localparam int TWBC_CT_MASTER = 4;
	localparam int TWBC_CT_TX     = 5;
	localparam int TWBC_CT_W      = 6;

	// Data levels captured on the link
	localparam int TWBC_DT_ACK = 0;
	localparam int TWBC_DT_RW  = 1;
	localparam int TWBC_DT_W   = 2;

	// Link-side condition generator states
	typedef enum logic [4:0] {
		TWBC_LK_IDLE    = 5'b00001,
		TWBC_LK_STA_REL = 5'b00010,
		TWBC_LK_STA_LOW = 5'b00100,
		TWBC_LK_STO_LOW = 5'b01000,
		TWBC_LK_STO_HI  = 5'b10000
	} twbc_link_e;

endpackage

// ---- twbc_sync.sv ----
// Two flip-flop level synchroniser, one stage pair per bit.
// Assumes each bit is a level or a toggle that holds for several target clocks.
`timescale 1ns/1ps
module twbc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,   // Target domain clock
	input  wire logic             rst_n_in, // Asynchronous reset, active low
	input  wire logic [WIDTH-1:0] d_in,     // Foreign-domain levels
	output logic      [WIDTH-1:0] q_out     // Synchronised levels
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} twbc_sync_s;

	twbc_sync_s r_reg;
	twbc_sync_s r_next;

	// First stage feeds only the second stage
	always_comb
	begin
		r_next    = r_reg;
		r_next.s1 = d_in;
		r_next.s2 = r_reg.s1;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign q_out = r_reg.s2;
endmodule // twbc_sync

// ---- twbc_link.sv ----
// Link-side engine: condition detection, bit counting, start/stop generation,
// acknowledge drive and clock stretching, all on the link clock.
// Assumes SCL pulses come from an external generator; pins are open drain.
`timescale 1ns/1ps
module twbc_link
	import twbc_pkg::*;
(
	input  wire logic                 link_clk_in, // Link clock
	input  wire logic                 rst_n_in,    // Asynchronous reset, active low
	input  wire logic                 sda_in,      // Data wire level
	input  wire logic                 scl_in,      // Clock wire level
	input  wire logic [TWBC_CT_W-1:0] ctrl_in,     // Controls from register domain
	output logic      [TWBC_EV_W-1:0] ev_out,      // Event toggles
	output logic      [TWBC_DT_W-1:0] dat_out,     // Captured ack and direction
	output logic                      sda_out,     // Data drive level
	output logic                      sda_oe_out,  // Data pull low enable
	output logic                      scl_out,     // Clock drive level
	output logic                      scl_oe_out   // Clock stretch enable
);
	typedef struct packed {
		twbc_link_e             state;
		logic [4:0]             cnt;
		logic [3:0]             bitcnt;
		logic                   in_frame;
		logic                   first;
		logic                   sda_prev;
		logic                   scl_prev;
		logic                   sta_prev;
		logic                   sto_prev;
		logic                   hold;
		logic                   hold_ref;
		logic                   ackev;
		logic [TWBC_EV_W-1:0]   ev;
		logic [TWBC_DT_W-1:0]   dat;
		logic                   sda_oe;
	} twbc_link_s;

	twbc_link_s           r_reg;
	twbc_link_s           r_next;
	logic [1:0]           pin_q;
	logic [TWBC_CT_W-1:0] ct_q;

	twbc_sync #(.WIDTH(2)) u_pin_sync (
		.clk_in   (link_clk_in),
		.rst_n_in (rst_n_in),
		.d_in     ({scl_in, sda_in}),
		.q_out    (pin_q)
	);

	twbc_sync #(.WIDTH(TWBC_CT_W)) u_ct_sync (
		.clk_in   (link_clk_in),
		.rst_n_in (rst_n_in),
		.d_in     (ctrl_in),
		.q_out    (ct_q)
	);

	// Bus watching and condition generation
	always_comb
	begin
		logic sda;
		logic scl;
		logic ack_drive;
		sda       = pin_q[0];
		scl       = pin_q[1];
		ack_drive = 1'b0;
		r_next          = r_reg;
		r_next.sda_prev = sda;
		r_next.scl_prev = scl;
		r_next.sta_prev = ct_q[TWBC_CT_STA];
		r_next.sto_prev = ct_q[TWBC_CT_STO];
		// Ack toggle moves one cycle after its value, so the value is settled
		r_next.ackev    = 1'b0;
		if (r_reg.ackev)
			r_next.ev[TWBC_EV_ACKVAL] = ~r_reg.ev[TWBC_EV_ACKVAL];
		// Stretch ends when software has cleared the serial event flag
		if (r_reg.hold && (ct_q[TWBC_CT_REL] != r_reg.hold_ref))
			r_next.hold = 1'b0;
		if (scl && r_reg.scl_prev && r_reg.sda_prev && !sda)
		begin
			r_next.ev[TWBC_EV_START] = ~r_reg.ev[TWBC_EV_START];
			r_next.in_frame = 1'b1;
			r_next.first    = 1'b1;
			r_next.bitcnt   = 4'h0;
		end
		else if (scl && r_reg.scl_prev && !r_reg.sda_prev && sda)
		begin
			r_next.ev[TWBC_EV_STOP] = ~r_reg.ev[TWBC_EV_STOP];
			r_next.in_frame = 1'b0;
			r_next.bitcnt   = 4'h0;
		end
		else if (r_reg.in_frame && scl && !r_reg.scl_prev)
		begin
			r_next.bitcnt = r_reg.bitcnt + 4'h1;
			if (r_reg.bitcnt == 4'h7 && r_reg.first)
				r_next.dat[TWBC_DT_RW] = sda;
			if (r_reg.bitcnt == 4'h8)
			begin
				r_next.dat[TWBC_DT_ACK] = ~sda; // Low wire means acknowledge
				r_next.ackev = 1'b1;
			end
		end
		else if (r_reg.in_frame && !scl && r_reg.scl_prev)
		begin
			if (r_reg.bitcnt == 4'h8 && !ct_q[TWBC_CT_TX])
			begin
				r_next.ev[TWBC_EV_ACKSLOT] = ~r_reg.ev[TWBC_EV_ACKSLOT];
				r_next.hold     = 1'b1;
				r_next.hold_ref = ct_q[TWBC_CT_REL];
			end
			if (r_reg.bitcnt == 4'h9)
			begin
				r_next.bitcnt = 4'h0;
				r_next.first  = 1'b0;
				if (ct_q[TWBC_CT_TX])
				begin
					r_next.hold     = 1'b1;
					r_next.hold_ref = ct_q[TWBC_CT_REL];
				end
			end
		end
		// Receiver pulls data low in the ninth bit when ack is set
		if (r_reg.in_frame && r_reg.bitcnt == 4'h8 && !scl && !ct_q[TWBC_CT_TX])
			ack_drive = ct_q[TWBC_CT_ACK];
		case (r_reg.state)
			TWBC_LK_IDLE:
			begin
				// Keep data low until clock is seen low, else a stop would form
				r_next.sda_oe = ack_drive | (r_reg.sda_oe & scl);
				if (ct_q[TWBC_CT_STA] && !r_reg.sta_prev)
					r_next.state = TWBC_LK_STA_REL;
				else if (ct_q[TWBC_CT_STO] && !r_reg.sto_prev && ct_q[TWBC_CT_MASTER])
					r_next.state = TWBC_LK_STO_LOW;
			end
			TWBC_LK_STA_REL:
			begin
				r_next.sda_oe = 1'b0;
				r_next.cnt    = 5'h00;
				if (scl && sda)
					r_next.state = TWBC_LK_STA_LOW;
				else if (scl && !sda && !r_reg.sda_oe)
				begin
					// Another master owns the wire
					r_next.ev[TWBC_EV_ARB] = ~r_reg.ev[TWBC_EV_ARB];
					r_next.state = TWBC_LK_IDLE;
				end
			end
			TWBC_LK_STA_LOW:
			begin
				r_next.sda_oe = 1'b1; // Data falls with clock high
				r_next.cnt    = r_reg.cnt + 5'h01;
				if (r_reg.cnt == TWBC_HOLD_CYC)
				begin
					r_next.ev[TWBC_EV_STARTED] = ~r_reg.ev[TWBC_EV_STARTED];
					r_next.hold     = 1'b1;
					r_next.hold_ref = ct_q[TWBC_CT_REL];
					r_next.state    = TWBC_LK_IDLE;
				end
			end
			TWBC_LK_STO_LOW:
			begin
				if (!scl)
				begin
					r_next.sda_oe = 1'b1;
					r_next.hold   = 1'b0;
					r_next.cnt    = 5'h00;
					r_next.state  = TWBC_LK_STO_HI;
				end
			end
			TWBC_LK_STO_HI:
			begin
				r_next.sda_oe = 1'b1;
				if (scl)
					r_next.cnt = r_reg.cnt + 5'h01;
				if (r_reg.cnt == TWBC_HOLD_CYC)
				begin
					r_next.sda_oe = 1'b0; // Data rises with clock high
					r_next.state  = TWBC_LK_IDLE;
				end
			end
			default:
				r_next.state = TWBC_LK_IDLE;
		endcase
	end

	always_ff @(posedge link_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			r_reg          <= '0;
			r_reg.state    <= TWBC_LK_IDLE;
			r_reg.sda_prev <= 1'b1;
			r_reg.scl_prev <= 1'b1;
		end
		else
			r_reg <= r_next;
	end

	assign ev_out     = r_reg.ev;
	assign dat_out    = r_reg.dat;
	assign sda_oe_out = r_reg.sda_oe;
	assign sda_out    = 1'b0;
	assign scl_oe_out = r_reg.hold;
	assign scl_out    = 1'b0;
endmodule // twbc_link

// ---- twbc_top.sv ----
// Two-wire bus control and status register with its link-side engine.
// Assumes an 8-bit special-function register bus on MCLK_IN and open-drain
// SDA/SCL pins resolved outside; the link engine runs on LINK_CLK_IN.
`timescale 1ns/1ps
module twbc_top
	import twbc_pkg::*;
(
	input  wire logic       MCLK_IN,       // System clock, 125 MHz
	input  wire logic       RST_N_IN,      // Asynchronous reset, active low
	input  wire logic       LINK_CLK_IN,   // Link-side engine clock
	input  wire logic [7:0] SFR_ADDR_IN,   // Register address
	input  wire logic       SFR_WR_IN,     // Write strobe
	input  wire logic       SFR_RD_IN,     // Read strobe
	input  wire logic [7:0] SFR_WDATA_IN,  // Write data
	output logic      [7:0] SFR_RDATA_OUT, // Read data, one cycle after strobe
	input  wire logic       SDA_IN,        // Data wire level
	output logic            SDA_OUT,       // Data drive level
	output logic            SDA_OE_OUT,    // Data pull low enable
	input  wire logic       SCL_IN,        // Clock wire level
	output logic            SCL_OUT,       // Clock drive level
	output logic            SCL_OE_OUT     // Clock stretch enable
);

	// Register-domain state
	typedef struct packed {
		logic                 master;
		logic                 tx;
		logic                 bus_begin_flag;
		logic                 halt_condition_flag;
		logic                 ackrq;
		logic                 arb;
		logic                 ack;
		logic                 si;
		logic                 sta_req;
		logic                 sto_req;
		logic                 rel;
		logic [TWBC_EV_W-1:0] ev_prev;
		logic [7:0]           rdata;
	} twbc_core_s;

	twbc_core_s           r_reg;
	twbc_core_s           r_next;
	logic [TWBC_EV_W-1:0] ev_raw;
	logic [TWBC_EV_W-1:0] ev_q;
	logic [TWBC_DT_W-1:0] dat_raw;
	logic [TWBC_DT_W-1:0] dat_q;
	logic [TWBC_CT_W-1:0] ctrl;

	// Address match, shared by read and write decode
	function automatic logic twbc_hit(input logic [7:0] addr);
		twbc_hit = (addr == TWBC_CTRL_ADDR);
	endfunction

	// Assemble the readable register image
	function automatic logic [7:0] twbc_image(input twbc_core_s s);
		logic [7:0] v;
		v                  = TWBC_CTRL_RESET;
		v[TWBC_MASTER_BIT] = s.master;
		v[TWBC_TX_BIT]     = s.tx;
		v[TWBC_BEGIN_BIT]  = s.bus_begin_flag;
		v[TWBC_HALT_BIT]   = s.halt_condition_flag;
		v[TWBC_ACKRQ_BIT]  = s.ackrq;
		v[TWBC_ARB_BIT]    = s.arb;
		v[TWBC_ACK_BIT]    = s.ack;
		v[TWBC_SI_BIT]     = s.si;
		twbc_image = v;
	endfunction

	// Controls handed to the link; all are register outputs, so safe to sync
	always_comb
	begin
		ctrl                 = '0;
		ctrl[TWBC_CT_STA]    = r_reg.sta_req;
		ctrl[TWBC_CT_STO]    = r_reg.sto_req;
		ctrl[TWBC_CT_ACK]    = r_reg.ack;
		ctrl[TWBC_CT_REL]    = r_reg.rel;
		ctrl[TWBC_CT_MASTER] = r_reg.master;
		ctrl[TWBC_CT_TX]     = r_reg.tx;
	end

	twbc_link u_link (
		.link_clk_in (LINK_CLK_IN),
		.rst_n_in    (RST_N_IN),
		.sda_in      (SDA_IN),
		.scl_in      (SCL_IN),
		.ctrl_in     (ctrl),
		.ev_out      (ev_raw),
		.dat_out     (dat_raw),
		.sda_out     (SDA_OUT),
		.sda_oe_out  (SDA_OE_OUT),
		.scl_out     (SCL_OUT),
		.scl_oe_out  (SCL_OE_OUT)
	);

	// Event toggles cross as levels; edges are found after the second stage
	twbc_sync #(.WIDTH(TWBC_EV_W)) u_ev_sync (
		.clk_in   (MCLK_IN),
		.rst_n_in (RST_N_IN),
		.d_in     (ev_raw),
		.q_out    (ev_q)
	);

	// Captured values settle a link cycle before their toggle moves
	twbc_sync #(.WIDTH(TWBC_DT_W)) u_dat_sync (
		.clk_in   (MCLK_IN),
		.rst_n_in (RST_N_IN),
		.d_in     (dat_raw),
		.q_out    (dat_q)
	);

	// Software access first, hardware events after, so an event beats a write in the same cycle
	always_comb
	begin
		logic [TWBC_EV_W-1:0] ev;
		logic                 wr;
		logic                 rd;
		ev = ev_q ^ r_reg.ev_prev;
		wr = SFR_WR_IN && twbc_hit(SFR_ADDR_IN);
		rd = SFR_RD_IN && twbc_hit(SFR_ADDR_IN);
		r_next         = r_reg;
		r_next.ev_prev = ev_q;

		// Register writes
		if (wr)
		begin
			if (SFR_WDATA_IN[TWBC_BEGIN_BIT])
			begin
				r_next.bus_begin_flag     = 1'b1;
				r_next.sta_req = 1'b1;
			end
			else
				r_next.bus_begin_flag = 1'b0;
			if (SFR_WDATA_IN[TWBC_HALT_BIT] && r_reg.master)
			begin
				r_next.halt_condition_flag     = 1'b1; // Pending until the stop is seen
				r_next.sto_req = 1'b1;
			end
			else if (!SFR_WDATA_IN[TWBC_HALT_BIT] && !r_reg.master)
				r_next.halt_condition_flag = 1'b0;
			// Slave response choice, sent inverted on the wire
			r_next.ack = SFR_WDATA_IN[TWBC_ACK_BIT];
			// Writing 1 to the event flag is ignored; only a clear releases
			if (!SFR_WDATA_IN[TWBC_SI_BIT] && r_reg.si)
			begin
				r_next.si    = 1'b0;
				r_next.ackrq = 1'b0;
				r_next.arb   = 1'b0;
				r_next.rel   = ~r_reg.rel; // Lets the link end its stretch
			end
		end

		// Start or repeated start seen on the wires
		if (ev[TWBC_EV_START])
			r_next.bus_begin_flag = 1'b1;

		// Own start completed: this end now owns the bus
		if (ev[TWBC_EV_STARTED])
		begin
			r_next.master  = 1'b1;
			r_next.tx      = 1'b1; // Address byte goes out first
			r_next.sta_req = 1'b0;
			r_next.si      = 1'b1;
		end

		// Lost the bus while trying to start
		if (ev[TWBC_EV_ARB])
		begin
			r_next.arb     = 1'b1;
			r_next.master  = 1'b0;
			r_next.tx      = 1'b0;
			r_next.sta_req = 1'b0;
			r_next.si      = 1'b1;
		end

		// Stop seen: master completes its stop, slave reports it
		if (ev[TWBC_EV_STOP])
		begin
			r_next.tx = 1'b0;
			if (r_reg.master)
			begin
				r_next.master  = 1'b0;
				r_next.halt_condition_flag     = 1'b0; // Cleared by hardware
				r_next.sto_req = 1'b0;
			end
			else
			begin
				r_next.halt_condition_flag = 1'b1;
				r_next.si  = 1'b1;
			end
		end

		// Receiver reached the acknowledge bit; the link holds the clock low
		if (ev[TWBC_EV_ACKSLOT])
		begin
			r_next.ackrq = 1'b1;
			r_next.si    = 1'b1;
		end

		// Acknowledge bit sampled on the wire
		if (ev[TWBC_EV_ACKVAL])
		begin
			if (r_reg.master)
			begin
				r_next.ack = dat_q[TWBC_DT_ACK]; // Received response
				r_next.tx  = ~dat_q[TWBC_DT_RW];
			end
			else
				r_next.tx = dat_q[TWBC_DT_RW]; // Master reading means we send
			if (r_reg.tx)
				r_next.si = 1'b1;
		end

		// Read data is registered; other cycles return zero
		if (rd)
			r_next.rdata = twbc_image(r_reg);
		else
			r_next.rdata = TWBC_CTRL_RESET;
	end

	// Single state register for the register domain
	always_ff @(posedge MCLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign SFR_RDATA_OUT = r_reg.rdata;
endmodule // twbc_top

// ---- twbc_top_props.sv ----
// Port checker for the two-wire bus control register block.
// Assumes it is bound onto twbc_top; register and link clock domains.
`timescale 1ns/1ps
module twbc_top_props
	import twbc_pkg::*;
(
	input wire logic       MCLK_IN,       // Clock
	input wire logic       RST_N_IN,      // Reset
	input wire logic       LINK_CLK_IN,   // Link clock
	input wire logic [7:0] SFR_ADDR_IN,   // Address
	input wire logic       SFR_WR_IN,     // Write
	input wire logic       SFR_RD_IN,     // Read
	input wire logic [7:0] SFR_WDATA_IN,  // Write data
	input wire logic [7:0] SFR_RDATA_OUT, // Read data
	input wire logic       SDA_IN,        // Data wire
	input wire logic       SDA_OUT,       // Data level
	input wire logic       SDA_OE_OUT,    // Data enable
	input wire logic       SCL_IN,        // Clock wire
	input wire logic       SCL_OUT,       // Clock level
	input wire logic       SCL_OE_OUT     // Clock enable
);
	logic [7:0] since_wr_reg; // Cycles since a register write
	logic [4:0] scl_hi_reg;   // Link cycles with clock wire high
	// Saturating, so a long idle never wraps into a false pass
	always_ff @(posedge MCLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			since_wr_reg <= 8'hff;
		else if (SFR_WR_IN && SFR_ADDR_IN == TWBC_CTRL_ADDR)
			since_wr_reg <= 8'h00;
		else if (since_wr_reg != 8'hff)
			since_wr_reg <= since_wr_reg + 8'h01;
	end
	// Raw wire count runs ahead of the synchronised one inside
	always_ff @(posedge LINK_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			scl_hi_reg <= 5'h00;
		else if (!SCL_IN)
			scl_hi_reg <= 5'h00;
		else if (scl_hi_reg != 5'h1f)
			scl_hi_reg <= scl_hi_reg + 5'h01;
	end
	sequence s_rd;
		SFR_RD_IN && SFR_ADDR_IN == TWBC_CTRL_ADDR;
	endsequence
	sequence s_wr_begin;
		SFR_WR_IN && SFR_ADDR_IN == TWBC_CTRL_ADDR && SFR_WDATA_IN[5];
	endsequence
	sequence s_wr_halt;
		SFR_WR_IN && SFR_ADDR_IN == TWBC_CTRL_ADDR && SFR_WDATA_IN[4];
	endsequence
	property p_rd_idle;
		@(posedge MCLK_IN) disable iff (!RST_N_IN) !(SFR_RD_IN && SFR_ADDR_IN == TWBC_CTRL_ADDR)
			|=> SFR_RDATA_OUT == 8'h00;
	endproperty
	property p_begin_set;
		@(posedge MCLK_IN) disable iff (!RST_N_IN) s_wr_begin ##2 s_rd |=> SFR_RDATA_OUT[5];
	endproperty
	property p_halt_pending;
		@(posedge MCLK_IN) disable iff (!RST_N_IN)
			s_rd ##1 SFR_RDATA_OUT[7] ##1 s_wr_halt ##2 s_rd |=> SFR_RDATA_OUT[4];
	endproperty
	property p_arb_si;
		@(posedge MCLK_IN) disable iff (!RST_N_IN)
			SFR_RDATA_OUT[2] |-> SFR_RDATA_OUT[0] && !SFR_RDATA_OUT[7];
	endproperty
	property p_stretch_hold;
		@(posedge MCLK_IN) disable iff (!RST_N_IN) $fell(SCL_OE_OUT) |-> since_wr_reg < 8'h50;
	endproperty
	property p_open_drain;
		@(posedge LINK_CLK_IN) disable iff (!RST_N_IN) SDA_OUT == 1'b0 && SCL_OUT == 1'b0;
	endproperty
	property p_start_hold;
		@(posedge LINK_CLK_IN) disable iff (!RST_N_IN)
			$rose(SDA_OE_OUT) && SCL_IN |-> (SDA_OE_OUT && !SCL_OE_OUT) [*8];
	endproperty
	property p_stop_hold;
		@(posedge LINK_CLK_IN) disable iff (!RST_N_IN)
			$fell(SDA_OE_OUT) && SCL_IN |-> scl_hi_reg >= TWBC_HOLD_CYC;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
	a_begin_set: assert property (p_begin_set) else $error("begin flag lost");
	a_halt_pending: assert property (p_halt_pending) else $error("halt not pending");
	a_arb_si: assert property (p_arb_si) else $error("arbitration flags wrong");
	a_stretch_hold: assert property (p_stretch_hold) else $error("stretch ended alone");
	a_open_drain: assert property (p_open_drain) else $error("pin level driven");
	a_start_hold: assert property (p_start_hold) else $error("start hold short");
	a_stop_hold: assert property (p_stop_hold) else $error("stop hold short");
endmodule // twbc_top_props

// ---- twbc_bus_model.sv ----
// Remote bus party: resolves both open-drain wires and acts as a master.
// Assumes the device drives enables only; both wires have pull-ups.
`timescale 1ns/1ps
module twbc_bus_model (
	input  wire logic sda_oe_in,  // Device pulls data low
	input  wire logic scl_oe_in,  // Device holds clock low
	output logic      sda_out,    // Data wire
	output logic      scl_out,    // Clock wire
	output int        starts_out, // Starts seen
	output int        stops_out,  // Stops seen
	output int        faults_out  // Stretch timeouts
);
	localparam int Q = 300; // Quarter bit time, ns
	logic sda_lo = 1'b0;
	logic scl_lo = 1'b0;
	// Pull-ups win unless a party pulls low
	assign sda_out = !(sda_oe_in || sda_lo);
	assign scl_out = !(scl_oe_in || scl_lo);
	initial
	begin
		starts_out = 0;
		stops_out = 0;
		faults_out = 0;
	end
	// Conditions on the wire
	always @(negedge sda_out) if (scl_out === 1'b1) starts_out++;
	always @(posedge sda_out) if (scl_out === 1'b1) stops_out++;
	// One clock pulse; waits out stretching, bounded
	task automatic pulse(input logic lo, output logic seen);
		int n;
		scl_lo = 1'b1;
		#1;
		sda_lo = lo; // Data moves only after clock is low
		#Q;
		scl_lo = 1'b0;
		n = 0;
		while (scl_out !== 1'b1 && n < 400)
		begin
			#10;
			n++;
		end
		if (n == 400) faults_out++;
		#Q;
		seen = sda_out;
		#Q;
		scl_lo = 1'b1;
		#Q;
	endtask
	task automatic m_byte(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) pulse(!b[i], s);
	endtask
	task automatic m_start();
		sda_lo = 1'b1;
		#Q;
	endtask
	task automatic m_stop();
		sda_lo = 1'b1;
		#Q;
		scl_lo = 1'b0;
		#Q;
		sda_lo = 1'b0;
		#Q;
	endtask
	// Data first, so releasing never forms a stop with the clock low
	task automatic release_bus();
		sda_lo = 1'b0;
		#1;
		scl_lo = 1'b0;
	endtask
	// Keep the clock low once the device lets go of its stretch
	task automatic m_hold();
		scl_lo = 1'b1;
	endtask
endmodule // twbc_bus_model

// ---- tb_twowire_bus_control_status.sv ----
// Self-checking bench for the two-wire bus control register block.
// Assumes twbc_top, the bus party model and the port checker compiled first.
`timescale 1ns/1ps
module tb_twowire_bus_control_status;
	import twbc_pkg::*;
	logic       mclk = 1'b0;
	logic       link_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic       sda_in;
	logic       sda_oe;
	logic       scl_in;
	logic       scl_oe;
	int         starts;
	int         stops;
	int         faults;
	int         bad_count = 0;
	int         checked = 0;
	int         acks[$] = '{1, 0}; // Ack choices per transfer
	int         mdl;               // Model register image
	always #4 mclk = !mclk;
	// Link clock offset so its phase is unrelated
	initial
	begin
		#3.3;
		forever #24 link_clk = !link_clk;
	end
	twbc_top twbc_top_inst (.MCLK_IN(mclk), .RST_N_IN(rst_n), .LINK_CLK_IN(link_clk),
		.SFR_ADDR_IN(addr), .SFR_WR_IN(wr), .SFR_RD_IN(rd), .SFR_WDATA_IN(wdata),
		.SFR_RDATA_OUT(rdata), .SDA_IN(sda_in), .SDA_OUT(), .SDA_OE_OUT(sda_oe),
		.SCL_IN(scl_in), .SCL_OUT(), .SCL_OE_OUT(scl_oe));
	twbc_bus_model twbc_bus_model_inst (.sda_oe_in(sda_oe), .scl_oe_in(scl_oe),
		.sda_out(sda_in), .scl_out(scl_in), .starts_out(starts), .stops_out(stops),
		.faults_out(faults));
	task automatic finish_test();
		$display("checked %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask
	// One bus cycle; inputs change just after the edge
	task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] v);
		wr = w;
		rd = r;
		addr = a;
		wdata = v;
		@(posedge mclk);
		#1;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		cyc(1'b1, 1'b0, a, v);
		cyc(1'b0, 1'b0, a, v);
	endtask
	task automatic rreg(input logic [7:0] a, output logic [7:0] q);
		cyc(1'b0, 1'b1, a, 8'h00);
		q = rdata;
		cyc(1'b0, 1'b0, a, 8'h00);
	endtask
	// Bounded poll until the masked bits match
	task automatic poll(input logic [7:0] m, input logic [7:0] v, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		#1;
		rreg(TWBC_CTRL_ADDR, q);
		while ((q & m) !== v && n < 500)
		begin
			rreg(TWBC_CTRL_ADDR, q);
			n++;
		end
		if (n == 500)
		begin
			$display("unexpected poll expected %h seen %h", v, q & m);
			bad_count++;
			finish_test();
		end
	endtask
	// Watchdog against a hung transfer
	initial
	begin
		#700000;
		bad_count++;
		finish_test();
	end
	initial
	begin
		logic [7:0] d;
		logic       seen;
		int         s0;
		int         p0;
		int         n;
		void'($urandom(32'h5846_69e2));
		repeat (5) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		s0 = starts;
		p0 = stops;
		// Reset value, unmapped address, read-only bits
		rreg(TWBC_CTRL_ADDR, d);
		chk("reset", TWBC_CTRL_RESET, d);
		wreg(8'(TWBC_CTRL_ADDR + 8'h01 + 8'($urandom_range(0, 254))), 8'h02);
		rreg(8'h00, d);
		chk("unmapped", 8'h00, d);
		wreg(TWBC_CTRL_ADDR, 8'hce);
		rreg(TWBC_CTRL_ADDR, d);
		chk("read only", 8'h02, d);
		wreg(TWBC_CTRL_ADDR, 8'h00);
		$display("test registers done");
		// Device as slave receiver, ack then nack
		foreach (acks[i])
		begin
			twbc_bus_model_inst.m_start();
			twbc_bus_model_inst.m_byte(8'($urandom) & 8'hfe);
			mdl = 32'h29;
			poll(8'h01, 8'h01, d);
			chk("slave byte", 8'(mdl), d);
			wreg(TWBC_CTRL_ADDR, 8'(acks[i] << 1));
			twbc_bus_model_inst.pulse(1'b0, seen);
			chk("ack wire", 8'(acks[i]), {7'h00, !seen});
			twbc_bus_model_inst.m_stop();
			mdl = 32'h11 | (acks[i] << 1);
			poll(8'h11, 8'h11, d);
			chk("slave stop", 8'(mdl), d & 8'hdf);
			wreg(TWBC_CTRL_ADDR, 8'h00);
		end
		$display("test slave done");
		// Device as master: start, repeated start, acks
		foreach (acks[i])
		begin
			wreg(TWBC_CTRL_ADDR, 8'h20);
			rreg(TWBC_CTRL_ADDR, d);
			chk("begin flag", 8'h20, d & 8'h20);
			twbc_bus_model_inst.release_bus();
			poll(8'h01, 8'h01, d);
			chk("master start", 8'he1, d);
			twbc_bus_model_inst.m_hold();
			wreg(TWBC_CTRL_ADDR, 8'h00);
			twbc_bus_model_inst.m_byte(8'hff);
			twbc_bus_model_inst.pulse(acks[i][0], seen);
			mdl = 32'h81 | (acks[i] << 1);
			poll(8'h01, 8'h01, d);
			chk("master ack", 8'(mdl), d & 8'hbf);
		end
		rreg(TWBC_CTRL_ADDR, d);
		chk("master", 8'h80, d & 8'h80);
		wreg(TWBC_CTRL_ADDR, 8'h10);
		rreg(TWBC_CTRL_ADDR, d);
		chk("halt pending", 8'h10, d & 8'h10);
		n = 0;
		while (sda_oe !== 1'b1 && n < 200)
		begin
			@(posedge mclk);
			n++;
		end
		if (n == 200)
		begin
			$display("unexpected stop drive expected 1 seen %b", sda_oe);
			bad_count++;
			finish_test();
		end
		#1;
		twbc_bus_model_inst.release_bus();
		poll(8'h90, 8'h00, d);
		chk("halt done", 8'h00, d & 8'h90);
		wreg(TWBC_CTRL_ADDR, 8'h00);
		$display("test master done");
		// Start request while another party holds data low
		twbc_bus_model_inst.m_start();
		poll(8'h20, 8'h20, d);
		chk("start seen", 8'h20, d & 8'h20);
		wreg(TWBC_CTRL_ADDR, 8'h20);
		poll(8'h01, 8'h01, d);
		chk("arbitration", 8'h05, d & 8'h85);
		wreg(TWBC_CTRL_ADDR, 8'h00);
		rreg(TWBC_CTRL_ADDR, d);
		chk("arb clear", 8'h00, d & 8'h05);
		twbc_bus_model_inst.release_bus();
		poll(8'h10, 8'h10, d);
		wreg(TWBC_CTRL_ADDR, 8'h00);
		chk("starts", 8'h05, 8'(starts - s0));
		chk("stops", 8'h04, 8'(stops - p0));
		chk("stretch", 8'h00, 8'(faults));
		$display("test arbitration done");
		finish_test();
	end
endmodule // tb_twowire_bus_control_status
bind twbc_top twbc_top_props twbc_top_props_inst (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
	.LINK_CLK_IN(LINK_CLK_IN), .SFR_ADDR_IN(SFR_ADDR_IN), .SFR_WR_IN(SFR_WR_IN),
	.SFR_RD_IN(SFR_RD_IN), .SFR_WDATA_IN(SFR_WDATA_IN), .SFR_RDATA_OUT(SFR_RDATA_OUT),
	.SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .SCL_IN(SCL_IN),
	.SCL_OUT(SCL_OUT), .SCL_OE_OUT(SCL_OE_OUT));
